// ### wbrc_top.sv
// reset control: watchdog and brown-out reset, supply flags, cause flags
// Summary of operation
// - watchdog overflow forces full system reset
// - watchdog counts until software clears it
// - reset runs detect, init, warm-up, fetch zero
// - after watchdog reset resume normal clock mode
// - hold reset while supply stays low
// - detector level set for reset resets system
// - lowest level always resets
// - lowest option disables both supply flags
// - middle option enables mid flag only
// - high option resets below middle, upper flag
// - maximum option resets below upper level
// - detector reset clears both supply flags
// - flags at status bits six and five
// - detector reset while running sets power-on cause flag
// - watchdog reset sets watchdog cause flag
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module wbrc_top #(
   parameter int unsigned WDT_LIMIT  = wbrc_pkg::WDT_LIMIT,
   parameter int unsigned WARMUP_CYC = wbrc_pkg::WARMUP_CYC
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       below_low_i,   // supply below lowest level
   input  wire logic       below_mid_i,   // supply at or below middle level
   input  wire logic       below_high_i,  // supply at or below upper level
   input  wire logic [1:0] detector_option_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            sys_rst_n_o,   // system reset, low while held
   output logic            fetch_start_o, // one pulse: fetch from address zero
   output logic            normal_mode_o, // high clock mode selected
   output logic            irq_o
);
   localparam int unsigned WW = $clog2(((WARMUP_CYC > wbrc_pkg::INIT_CYC) ?
                                        WARMUP_CYC : wbrc_pkg::INIT_CYC) + 1);
   localparam logic [WW-1:0] WARM_TOP = WW'(WARMUP_CYC - 1);
   localparam logic [WW-1:0] INIT_TOP = WW'(wbrc_pkg::INIT_CYC - 1);

   // complete state of the block
   typedef struct packed {
      wbrc_pkg::wbrc_st_e seq;     // reset sequence state
      logic [WW-1:0]      cnt;     // sequence timer
      logic               mid_f;   // supply flag, middle level
      logic               high_f;  // supply flag, upper level
      logic               por_f;   // cause: detector or power-on
      logic               wdt_f;   // cause: watchdog
      logic               global_irq_enable;     // global interrupt enable bit
      logic [2:0]         stack_pointer_supply_status;    // stack pointer bits
      logic [2:0]         ists;    // sticky interrupt status
      logic [2:0]         imsk;    // interrupt mask
      logic [7:0]         rdata;   // read data
      logic               rst_n;   // system reset out
      logic               fetch;   // fetch pulse
      logic               normal;  // normal clock mode
      logic               slow;    // slow mode request, only ever cleared
      logic               irq;     // interrupt out
      logic               mid_p;   // previous middle flag for edge
      logic               high_p;  // previous upper flag for edge
      logic               near_p;  // previous near-overflow
   } wbrc_s;
   wbrc_s st_q;
   wbrc_s st_d;

   logic [2:0] cmp_s;    // synchronised comparators
   logic       wdt_ovf;  // watchdog overflow pulse
   logic       wdt_near; // watchdog past half count
   logic       wdt_clr;  // software restart of watchdog
   logic       running;  // program executing
   wbrc_pkg::wbrc_opt_e opt;

   assign opt     = wbrc_pkg::wbrc_opt_e'(detector_option_i);
   assign running = (st_q.seq == wbrc_pkg::WBRC_ST_RUN);
   assign wdt_clr = wr_i && addr_i == wbrc_pkg::ADDR_WDT_CLR
                    && wdata_i == wbrc_pkg::WDT_CLR_KEY;

   // comparator levels cross into the clock domain
   wbrc_sync #(.W(3)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({below_high_i, below_mid_i, below_low_i}),
      .sync_o    (cmp_s)
   );

   // watchdog counter, held at zero outside normal execution
   wbrc_wdog #(.LIMIT(WDT_LIMIT)) u_wdog (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .run_i     (running),
      .clear_i   (wdt_clr),
      .ovf_o     (wdt_ovf),
      .near_o    (wdt_near)
   );

   // detector reset request per option
   logic lvd_rst;
   always_comb begin
      lvd_rst = cmp_s[0];
      case (opt)
         wbrc_pkg::WBRC_OPT_LOWEST:  lvd_rst = cmp_s[0];
         wbrc_pkg::WBRC_OPT_MIDDLE:  lvd_rst = cmp_s[0];
         wbrc_pkg::WBRC_OPT_HIGH:    lvd_rst = cmp_s[0] | cmp_s[1];
         wbrc_pkg::WBRC_OPT_MAXIMUM: lvd_rst = |cmp_s;
         default:                    lvd_rst = cmp_s[0];
      endcase
   end

   // supply flag values per option; disabled flags read zero
   logic mid_v;
   logic high_v;
   always_comb begin
      mid_v  = 1'b0;
      high_v = 1'b0;
      case (opt)
         wbrc_pkg::WBRC_OPT_LOWEST:  begin mid_v = 1'b0;     high_v = 1'b0;     end
         wbrc_pkg::WBRC_OPT_MIDDLE:  begin mid_v = cmp_s[1]; high_v = 1'b0;     end
         wbrc_pkg::WBRC_OPT_HIGH:    begin mid_v = 1'b0;     high_v = cmp_s[2]; end
         wbrc_pkg::WBRC_OPT_MAXIMUM: begin mid_v = 1'b0;     high_v = 1'b0;     end
         default:                    begin mid_v = 1'b0;     high_v = 1'b0;     end
      endcase
   end

   // next state: sequence, flags, registers, interrupt
   always_comb begin
      st_d       = st_q;
      st_d.fetch = 1'b0;
      st_d.rdata = 8'h00;
      st_d.mid_p  = st_q.mid_f;
      st_d.high_p = st_q.high_f;
      st_d.near_p = wdt_near;
      // reset sequencer
      case (st_q.seq)
         wbrc_pkg::WBRC_ST_HOLD: begin
            st_d.rst_n = 1'b0;
            st_d.cnt   = '0;
            if (!lvd_rst) begin
               st_d.seq = wbrc_pkg::WBRC_ST_INIT;
            end
         end
         wbrc_pkg::WBRC_ST_INIT: begin
            // system registers take their initial values
            st_d.global_irq_enable    = 1'b0;
            st_d.stack_pointer_supply_status   = wbrc_pkg::STACK_POINTER_SUPPLY_STATUS_RST;
            st_d.slow   = 1'b0;
            st_d.normal = 1'b1;
            st_d.imsk   = '0;
            st_d.ists   = '0;
            st_d.cnt    = st_q.cnt + WW'(1);
            if (lvd_rst) begin
               st_d.seq = wbrc_pkg::WBRC_ST_HOLD;
            end else if (st_q.cnt == INIT_TOP) begin
               st_d.cnt = '0;
               st_d.seq = wbrc_pkg::WBRC_ST_WARM;
            end
         end
         wbrc_pkg::WBRC_ST_WARM: begin
            st_d.cnt = st_q.cnt + WW'(1);
            if (lvd_rst) begin
               st_d.seq = wbrc_pkg::WBRC_ST_HOLD;
            end else if (st_q.cnt == WARM_TOP) begin
               st_d.seq   = wbrc_pkg::WBRC_ST_RUN;
               st_d.rst_n = 1'b1;
               st_d.fetch = 1'b1;
            end
         end
         wbrc_pkg::WBRC_ST_RUN: begin
            if (lvd_rst) begin
               st_d.seq   = wbrc_pkg::WBRC_ST_HOLD;
               st_d.rst_n = 1'b0;
               st_d.por_f = 1'b1;
               st_d.wdt_f = 1'b0;
            end else if (wdt_ovf) begin
               st_d.seq   = wbrc_pkg::WBRC_ST_HOLD;
               st_d.rst_n = 1'b0;
               st_d.wdt_f = 1'b1;
               st_d.por_f = 1'b0;
            end
         end
         default: begin
            st_d.seq = wbrc_pkg::WBRC_ST_HOLD;
         end
      endcase
      // supply flags follow comparators while running, cleared in reset
      if (lvd_rst || st_q.seq != wbrc_pkg::WBRC_ST_RUN) begin
         st_d.mid_f  = 1'b0;
         st_d.high_f = 1'b0;
      end else begin
         st_d.mid_f  = mid_v;
         st_d.high_f = high_v;
      end
      // register writes while running
      if (wr_i && running) begin
         if (addr_i == wbrc_pkg::ADDR_STATUS) begin
            st_d.global_irq_enable  = wdata_i[wbrc_pkg::BIT_GIE];
            st_d.stack_pointer_supply_status = wdata_i[2:0];
         end
         if (addr_i == wbrc_pkg::ADDR_IRQ_MASK) begin
            st_d.imsk = wdata_i[2:0];
         end
      end
      // register reads
      if (rd_i) begin
         case (addr_i)
            wbrc_pkg::ADDR_STATUS: begin
               st_d.rdata[wbrc_pkg::BIT_GIE]  = st_q.global_irq_enable;
               st_d.rdata[wbrc_pkg::BIT_MID]  = st_q.mid_f;
               st_d.rdata[wbrc_pkg::BIT_HIGH] = st_q.high_f;
               st_d.rdata[2:0]                = st_q.stack_pointer_supply_status;
            end
            wbrc_pkg::ADDR_PROGRAM_FLAG_REGISTER: begin
               st_d.rdata[wbrc_pkg::BIT_POR] = st_q.por_f;
               st_d.rdata[wbrc_pkg::BIT_WDT] = st_q.wdt_f;
            end
            wbrc_pkg::ADDR_IRQ_STAT: st_d.rdata = {5'h00, st_q.ists};
            wbrc_pkg::ADDR_IRQ_MASK: st_d.rdata = {5'h00, st_q.imsk};
            default:                 st_d.rdata = 8'h00;
         endcase
      end
      // sticky status: read clears, a new event in the same cycle wins
      if (rd_i && addr_i == wbrc_pkg::ADDR_IRQ_STAT) begin
         st_d.ists = '0;
      end
      if (st_q.mid_f && !st_q.mid_p) begin
         st_d.ists[wbrc_pkg::IRQ_MID] = 1'b1;
      end
      if (st_q.high_f && !st_q.high_p) begin
         st_d.ists[wbrc_pkg::IRQ_HIGH] = 1'b1;
      end
      if (wdt_near && !st_q.near_p && running) begin
         st_d.ists[wbrc_pkg::IRQ_NEARWDT] = 1'b1;
      end
      st_d.irq = |(st_d.ists & st_d.imsk);
   end

   // single state register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q        <= '0;
         st_q.seq    <= wbrc_pkg::WBRC_ST_HOLD;
         st_q.por_f  <= 1'b1;
         st_q.stack_pointer_supply_status   <= wbrc_pkg::STACK_POINTER_SUPPLY_STATUS_RST;
         st_q.normal <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata_o       = st_q.rdata;
   assign sys_rst_n_o   = st_q.rst_n;
   assign fetch_start_o = st_q.fetch;
   assign normal_mode_o = st_q.normal;
   assign irq_o         = st_q.irq;

   initial begin
      if (WARMUP_CYC < 1) $error("wbrc_top: warm-up must be at least one cycle");
   end

   // overflow while running drops reset next cycle
   wdog_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      running && wdt_ovf && !lvd_rst |=> !sys_rst_n_o && st_q.wdt_f)
      else $error("watchdog overflow did not reset");
   // detector reset sets power-on cause
   lvd_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      running && lvd_rst |=> !sys_rst_n_o && st_q.por_f && !st_q.wdt_f)
      else $error("detector reset cause wrong");
   // held while supply stays low
   hold_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      lvd_rst |=> !running)
      else $error("left reset while supply low");
   // lowest level always resets
   lowest_rst_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmp_s[0] |-> lvd_rst)
      else $error("lowest level did not request reset");
   // maximum option resets on upper comparator
   max_rst_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      opt == wbrc_pkg::WBRC_OPT_MAXIMUM && cmp_s[2] |-> lvd_rst)
      else $error("maximum option did not reset");
   // flags cleared in every reset phase
   flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !running |=> !st_q.mid_f && !st_q.high_f)
      else $error("supply flag survived reset");
   // lowest option keeps flags zero
   lowest_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      opt == wbrc_pkg::WBRC_OPT_LOWEST |=> !st_q.mid_f && !st_q.high_f)
      else $error("flag set under lowest option");
   // middle flag tracks comparator
   mid_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      running && !lvd_rst && opt == wbrc_pkg::WBRC_OPT_MIDDLE |=> st_q.mid_f == $past(cmp_s[1]))
      else $error("middle flag wrong");
   // status read shows flags at bits six and five
   status_rd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_i && addr_i == wbrc_pkg::ADDR_STATUS |=>
      rdata_o[6] == $past(st_q.mid_f) && rdata_o[5] == $past(st_q.high_f))
      else $error("status read wrong");
   // release comes with fetch pulse and normal mode
   release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(sys_rst_n_o) |-> fetch_start_o && normal_mode_o)
      else $error("release without fetch or normal mode");
   // sequence initialises registers and clock mode
   init_regs_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      st_q.seq == wbrc_pkg::WBRC_ST_INIT |=>
      !st_q.global_irq_enable && st_q.stack_pointer_supply_status == wbrc_pkg::STACK_POINTER_SUPPLY_STATUS_RST && normal_mode_o)
      else $error("registers not initialised by reset sequence");
   // fetch pulse lasts one cycle
   fetch_once_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      fetch_start_o |=> !fetch_start_o)
      else $error("fetch pulse longer than one cycle");
   // no fetch while supply stays low
   hold_fetch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      lvd_rst |=> !fetch_start_o && !sys_rst_n_o)
      else $error("fetch started while supply low");
   // restart keeps the overflow away
   wdog_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      wdt_clr |=> !wdt_ovf [*3])
      else $error("overflow right after watchdog restart");
   // high option resets on middle comparator
   mid_rst_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      opt == wbrc_pkg::WBRC_OPT_HIGH && cmp_s[1] |-> lvd_rst)
      else $error("high option did not reset below middle level");
   // upper flag tracks comparator under high option
   high_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      running && !lvd_rst && opt == wbrc_pkg::WBRC_OPT_HIGH |=>
      st_q.high_f == $past(cmp_s[2]))
      else $error("upper flag wrong");
   // middle option keeps upper flag zero
   upper_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      opt == wbrc_pkg::WBRC_OPT_MIDDLE |=> !st_q.high_f)
      else $error("upper flag set under middle option");
   // one reset cause at a time
   cause_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !(st_q.por_f && st_q.wdt_f))
      else $error("both reset causes set");

   wdog_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) running && wdt_ovf);
   lvd_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) running && lvd_rst);
   boot_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(sys_rst_n_o));
   irq_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(irq_o));
   hold_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) !running && lvd_rst);
endmodule : wbrc_top

// ### wbrc_pkg.sv
// package of constants and types for the watchdog and brown-out reset control
package wbrc_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned WARMUP_US     = 100;
   localparam int unsigned WARMUP_CYC    = (WARMUP_US * (CLK_HZ / 1_000_000) > 0) ?
                                           WARMUP_US * (CLK_HZ / 1_000_000) : 1;
   localparam int unsigned INIT_CYC      = 4;
   localparam int unsigned WDT_LIMIT     = 65536;
   // register map
   localparam logic [7:0] ADDR_STATUS    = 8'hef;
   localparam logic [7:0] ADDR_PROGRAM_FLAG_REGISTER     = 8'h86;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'hf0;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'hf1;
   localparam logic [7:0] ADDR_WDT_CLR   = 8'hf2;
   // status register fields
   localparam int unsigned BIT_GIE       = 7;
   localparam int unsigned BIT_MID       = 6;
   localparam int unsigned BIT_HIGH      = 5;
   localparam logic [2:0] STACK_POINTER_SUPPLY_STATUS_RST       = 3'h7;
   // program flag fields
   localparam int unsigned BIT_POR       = 7;
   localparam int unsigned BIT_WDT       = 6;
   // interrupt status fields and watchdog clear key
   localparam int unsigned IRQ_MID       = 0;
   localparam int unsigned IRQ_HIGH      = 1;
   localparam int unsigned IRQ_NEARWDT   = 2;
   localparam logic [7:0] WDT_CLR_KEY    = 8'h5a;
   // detector options
   typedef enum logic [1:0] {
      WBRC_OPT_LOWEST,
      WBRC_OPT_MIDDLE,
      WBRC_OPT_HIGH,
      WBRC_OPT_MAXIMUM
   } wbrc_opt_e;
   // reset sequence states
   typedef enum logic [1:0] {
      WBRC_ST_HOLD,
      WBRC_ST_INIT,
      WBRC_ST_WARM,
      WBRC_ST_RUN
   } wbrc_st_e;
endpackage : wbrc_pkg

// ### wbrc_sync.sv
// two-flop synchroniser for the comparator levels
`timescale 1ns/1ps
module wbrc_sync #(
   parameter int unsigned W = 3
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   // state: first and second stages
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } wbrc_sync_s;
   wbrc_sync_s st_q;
   wbrc_sync_s st_d;

   // shift the level one stage per clock
   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
   end

   // register the stages; reset reads as supply good
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.s2;

   initial begin
      if (W < 1) $error("wbrc_sync: width must be at least one");
   end
endmodule : wbrc_sync

// ### wbrc_wdog.sv
// watchdog counter: counts up, restarted by software, pulses on overflow
`timescale 1ns/1ps
module wbrc_wdog #(
   parameter int unsigned LIMIT = wbrc_pkg::WDT_LIMIT
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic run_i,
   input  wire logic clear_i,
   output logic      ovf_o,
   output logic      near_o
);
   localparam int unsigned CW = $clog2(LIMIT);
   localparam logic [CW-1:0] TOP = CW'(LIMIT - 1);
   // state: count and overflow pulse
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          ovf;
   } wbrc_wdog_s;
   wbrc_wdog_s st_q;
   wbrc_wdog_s st_d;

   // count while running, restart on a clear, held at zero during reset sequence
   always_comb begin
      st_d     = st_q;
      st_d.ovf = 1'b0;
      if (!run_i || clear_i) begin
         st_d.cnt = '0;
      end else if (st_q.cnt == TOP) begin
         st_d.cnt = '0;
         st_d.ovf = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign ovf_o  = st_q.ovf;
   assign near_o = st_q.cnt[CW-1];

   initial begin
      if (LIMIT < 4) $error("wbrc_wdog: limit too small");
   end
endmodule : wbrc_wdog

// ### wbrc_supply_model.sv
// behavioural model of the supply comparators that feed the reset control
`timescale 1ns/1ps
module wbrc_supply_model #(
   parameter int unsigned LOW_MV  = 1800, // lowest detector level, mV
   parameter int unsigned MID_MV  = 2400, // middle detector level, mV
   parameter int unsigned HIGH_MV = 3300  // upper detector level, mV
) (
   input  wire logic [15:0] supply_mv_i,  // supply level in millivolts
   output logic             below_low_o,  // supply below lowest level
   output logic             below_mid_o,  // supply at or below middle level
   output logic             below_high_o  // supply at or below upper level
);
   // comparators are analog: they move with the supply, not with any clock
   // lowest comparator trips strictly below its level
   assign below_low_o  = ({16'h0, supply_mv_i} < LOW_MV);
   // flag comparators trip at or below their levels
   assign below_mid_o  = ({16'h0, supply_mv_i} <= MID_MV);
   assign below_high_o = ({16'h0, supply_mv_i} <= HIGH_MV);
endmodule : wbrc_supply_model

// ### wbrc_top_tb.sv
// self-checking testbench for the watchdog and brown-out reset control
`timescale 1ns/1ps
module wbrc_top_tb;
   localparam int unsigned T_WDT  = 64; // shortened watchdog overflow count
   localparam int unsigned T_WARM = 3;  // shortened oscillator warm-up
   logic        clk;          // 50 MHz clock
   logic        rst_n;        // power-on reset, active low
   logic [15:0] supply_mv;    // supply level seen by the comparators
   logic        below_low;    // comparator outputs
   logic        below_mid;
   logic        below_high;
   logic [1:0]  option;       // detector option
   logic [7:0]  addr;         // register port
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        sys_rst_n;    // design outputs
   logic        fetch_start;
   logic        normal_mode;
   logic        irq;
   logic [7:0]  d;            // last read value
   int          n_fail;       // mismatches
   int          checked;      // comparisons made
   int          n;

   wbrc_supply_model i_supply (.supply_mv_i(supply_mv), .below_low_o(below_low),
      .below_mid_o(below_mid), .below_high_o(below_high));

   wbrc_top #(.WDT_LIMIT(T_WDT), .WARMUP_CYC(T_WARM)) i_dut (.ref_clk_i(clk),
      .rst_n_i(rst_n), .below_low_i(below_low), .below_mid_i(below_mid),
      .below_high_i(below_high), .detector_option_i(option), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sys_rst_n_o(sys_rst_n),
      .fetch_start_o(fetch_start), .normal_mode_o(normal_mode), .irq_o(irq));

   // clock generator
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // prints the verdict and ends the run
   task automatic complete_run;
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   // compares a seen value with the expected one
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // one-cycle register write
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // one-cycle register read, data taken in the following cycle
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg

   // restarts the watchdog; the only place the bench clears it
   task automatic kick;
      wr_reg(wbrc_pkg::ADDR_WDT_CLR, wbrc_pkg::WDT_CLR_KEY);
   endtask : kick

   // waits for the end of a reset sequence and checks how it ends
   task automatic wait_run(input int max_cyc);
      int k;
      k = 0;
      while (sys_rst_n !== 1'b1 && k < max_cyc) begin
         @(posedge clk);
         #1;
         k++;
      end
      check({7'h0, sys_rst_n}, 8'h01, "reset release");
      check(8'(k >= wbrc_pkg::INIT_CYC + T_WARM), 8'h01, "warm-up span");
      check({7'h0, fetch_start}, 8'h01, "fetch pulse");
      check({7'h0, normal_mode}, 8'h01, "normal clock mode");
      @(posedge clk);
      #1 check({7'h0, fetch_start}, 8'h00, "fetch pulse length");
   endtask : wait_run

   // one detector option at one supply level
   task automatic step(input logic [1:0] opt, input int mv);
      logic       rst_x;
      logic [7:0] fl;
      rst_x = (mv < 1800) || (opt == 2'h2 && mv <= 2400) || (opt == 2'h3 && mv <= 3300);
      fl = {1'b0, (opt == 2'h1 && mv <= 2400), (opt == 2'h2 && mv <= 3300), 5'h0};
      kick();
      @(posedge clk);
      option <= opt;
      supply_mv <= 16'(mv);
      repeat (5) @(posedge clk);
      #1 check({7'h0, sys_rst_n}, {7'h0, !rst_x}, "detector reset");
      if (!rst_x) begin
         // running: only the enabled flag may show
         rd_reg(wbrc_pkg::ADDR_STATUS, d);
         check(d & 8'h60, fl, "supply flags");
      end else begin
         // supply stays low: reset must not finish
         repeat (30) @(posedge clk);
         #1 check({7'h0, sys_rst_n}, 8'h00, "held in reset");
         @(posedge clk);
         supply_mv <= 16'd3600;
         wait_run(40);
         rd_reg(wbrc_pkg::ADDR_PROGRAM_FLAG_REGISTER, d);
         check(d & 8'hc0, 8'h80, "detector cause");
         rd_reg(wbrc_pkg::ADDR_STATUS, d);
         check(d & 8'h60, 8'h00, "flags after detector reset");
      end
   endtask : step

   // timeout guard, far beyond the expected run length
   initial begin
      #400_000;
      n_fail++;
      complete_run();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      supply_mv = 16'd3600;
      option = 2'h0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      n_fail = 0;
      checked = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wait_run(40);
      // reset values, read-only bits, unmapped place
      rd_reg(wbrc_pkg::ADDR_PROGRAM_FLAG_REGISTER, d);
      check(d & 8'hc0, 8'h80, "power-on cause");
      rd_reg(wbrc_pkg::ADDR_STATUS, d);
      check(d, 8'h07, "status after reset");
      wr_reg(wbrc_pkg::ADDR_STATUS, 8'hff);
      rd_reg(wbrc_pkg::ADDR_STATUS, d);
      check(d, 8'h87, "status read-only bits");
      wr_reg(8'h10, 8'hff);
      rd_reg(8'h10, d);
      check(d, 8'h00, "unmapped read");
      // watchdog cleared in time never resets
      for (int i = 0; i < 5; i++) begin
         kick();
         repeat (40) @(posedge clk);
         #1 check({7'h0, sys_rst_n}, 8'h01, "no reset while cleared");
      end
      rd_reg(wbrc_pkg::ADDR_IRQ_STAT, d);
      check(d & 8'h04, 8'h04, "near-overflow event");
      // wrong key does not restart it, so it overflows
      n = 0;
      while (sys_rst_n === 1'b1 && n < 100) begin
         wr_reg(wbrc_pkg::ADDR_WDT_CLR, 8'h00);
         #1;
         n++;
      end
      check({7'h0, sys_rst_n}, 8'h00, "watchdog reset");
      wait_run(40);
      rd_reg(wbrc_pkg::ADDR_PROGRAM_FLAG_REGISTER, d);
      check(d & 8'hc0, 8'h40, "watchdog cause");
      rd_reg(wbrc_pkg::ADDR_STATUS, d);
      check(d, 8'h07, "status initialised");
      rd_reg(wbrc_pkg::ADDR_IRQ_STAT, d);
      check(d, 8'h00, "interrupt status initialised");
      // every detector option at three supply levels
      for (int o = 0; o < 4; o++) begin
         step(2'(o), 3000);
         step(2'(o), 2000);
         step(2'(o), 1500);
      end
      // interrupt from the middle flag: masked, then unmasked and cleared
      kick();
      @(posedge clk);
      option <= 2'h1;
      wr_reg(wbrc_pkg::ADDR_IRQ_MASK, 8'h00);
      rd_reg(wbrc_pkg::ADDR_IRQ_STAT, d);
      @(posedge clk);
      supply_mv <= 16'd2000;
      repeat (6) @(posedge clk);
      #1 check({7'h0, irq}, 8'h00, "masked interrupt");
      rd_reg(wbrc_pkg::ADDR_IRQ_STAT, d);
      check(d & 8'h03, 8'h01, "mid flag event");
      kick();
      wr_reg(wbrc_pkg::ADDR_IRQ_MASK, 8'h01);
      @(posedge clk);
      supply_mv <= 16'd3600;
      repeat (6) @(posedge clk);
      supply_mv <= 16'd2000;
      repeat (6) @(posedge clk);
      #1 check({7'h0, irq}, 8'h01, "unmasked interrupt");
      rd_reg(wbrc_pkg::ADDR_IRQ_STAT, d);
      check(d & 8'h03, 8'h01, "event before clear");
      repeat (2) @(posedge clk);
      #1 check({7'h0, irq}, 8'h00, "interrupt cleared by read");
      complete_run();
   end
endmodule : wbrc_top_tb
